// ==== rtl/ptl_pkg.sv ====
// Shared constants, types and helpers for the tug3 label and multiframe sink
package ptl_pkg;

   // ****************************************************
   // Timing
   // ****************************************************
   localparam int CLK_MHZ = 125;             // Clock rate in MHz
   localparam int LOM_TIME_US = 3000;        // Loss-of-multiframe wait, us
   localparam int LOM_CYCLES = LOM_TIME_US * CLK_MHZ; // Wait in clocks
   localparam int ALIGN_FRAMES = 4;          // Clean frames to realign
   localparam int ACCEPT_FRAMES = 5;         // Equal labels to accept

   // ****************************************************
   // Multiframe status byte fields (bit 1 is the MSB)
   // ****************************************************
   localparam int LABEL_LSB = 3;             // Bits 3 to 5 -> data[5:3]
   localparam int SEQ_LSB = 1;               // Bits 6 to 7 -> data[2:1]
   localparam logic [2:0] EXP_LABEL = 3'h4;  // Two TUG-3 plus five TUG-2
   localparam logic [1:0] MF_START_CODE = 2'h0; // Code of the first frame

   // ****************************************************
   // Register map (byte addresses) and fields
   // ****************************************************
   localparam int ADDR_W = 5;
   localparam logic [4:0] CTRL_OFS = 5'h00;
   localparam logic [4:0] STAT_OFS = 5'h04;
   localparam logic [4:0] INT_STAT_OFS = 5'h08;
   localparam logic [4:0] INT_MASK_OFS = 5'h0c;
   localparam logic [4:0] TRIB_OFS = 5'h10;
   localparam logic CTRL_RST = 1'h1;         // Function active after reset
   localparam logic [7:0] TRIB_RST = 8'h00;
   localparam logic [1:0] INT_MASK_RST = 2'h0;
   localparam int INT_PLM_BIT = 0;           // Label mismatch cause rose
   localparam int INT_LOM_BIT = 1;           // Multiframe loss cause rose

   // ****************************************************
   // Types
   // ****************************************************
   // Byte stream beat: data, frame start, status byte marker
   typedef struct packed {
      logic [7:0] data;
      logic fs;
      logic ma_en;
   } ptl_strm_s;

   // Tributary selector: vc3 mode, K, L, M group indices
   typedef struct packed {
      logic vc3;
      logic [1:0] m;
      logic [2:0] l;
      logic [1:0] k;
   } ptl_trib_s;

   typedef enum logic [1:0] {
      out_of_alignment_state = 2'b01,
      aligned_state = 2'b10
   } ptl_align_e;

   // Sequence code that must follow the given one
   function automatic logic [1:0] ptl_next_code(input logic [1:0] c);
      ptl_next_code = c + 2'h1;
   endfunction

   // Group indices legal for the selected tributary kind
   function automatic logic ptl_trib_ok(input ptl_trib_s t);
      logic [2:0] lmax;
      lmax = (t.k == 2'h2) ? 3'h5 : 3'h7;
      if (t.vc3) begin
         ptl_trib_ok = (t.k <= 2'h1) && (t.l == 3'h0) && (t.m == 2'h0);
      end else begin
         ptl_trib_ok = (t.k <= 2'h2) && (t.l >= 3'h1) && (t.l <= lmax);
      end
   endfunction

endpackage

// ==== rtl/ptl_label_chk.sv ====
// Payload structure label acceptance and mismatch detection
`timescale 1ns/1ns
module ptl_label_chk
   import ptl_pkg::*;
#(
   parameter int ACCEPT_N = ACCEPT_FRAMES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Status byte input
   input wire logic en_i,
   input wire logic ma_en_i,
   input wire logic [2:0] label_i,
   // Results
   output logic [2:0] accepted_o,
   output logic mismatch_o
);
   logic [2:0] cand;   // Label seen in the last frames
   logic [3:0] same;   // Frames the candidate has persisted

   // ****************************************************
   // Acceptance: a label counts once it repeats in a row
   // ****************************************************
   // A single corrupted byte cannot flip the accepted label this way
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !en_i) begin
         cand <= EXP_LABEL;
         same <= 4'h0;
         accepted_o <= EXP_LABEL;
      end else if (ma_en_i) begin
         if (label_i != cand) begin
            cand <= label_i;
            same <= 4'h1;
         end else if (same < 4'(ACCEPT_N)) begin
            same <= same + 4'h1;
            if (same == 4'(ACCEPT_N - 1)) begin
               accepted_o <= label_i;
            end
         end
      end
   end

   // Mismatch follows the accepted label against the fixed code
   assign mismatch_o = (accepted_o != EXP_LABEL);

   // ****************************************************
   // Checks
   // ****************************************************
   mismatch_def_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      $rose(mismatch_o) |-> $past(ma_en_i) && $past(en_i)
         && $past(label_i) != EXP_LABEL)
      else $error("mismatch defect rose without a differing label");

   label_accept_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      $changed(accepted_o) && $past(en_i) && en_i |->
         accepted_o == $past(label_i))
      else $error("label accepted without being seen");

endmodule

// ==== rtl/ptl_mf_align.sv ====
// Multiframe alignment on the two-bit sequence and loss timer
`timescale 1ns/1ns
module ptl_mf_align
   import ptl_pkg::*;
#(
   parameter int LOM_N = LOM_CYCLES,
   parameter int ALIGN_N = ALIGN_FRAMES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Status byte input
   input wire logic en_i,
   input wire logic ma_en_i,
   input wire logic [1:0] code_i,
   // Results
   output logic aligned_o,
   output logic mf_start_o,
   output logic lom_o
);
   localparam int TW = $clog2(LOM_N + 1);
   ptl_align_e state;      // Alignment state
   logic [1:0] exp_code;   // Code expected in the next frame
   logic [2:0] good;       // Error-free frames while out of alignment
   logic [TW-1:0] timer;   // Clocks spent out of alignment
   logic seq_ok;

   assign seq_ok = (code_i == exp_code);

   // ****************************************************
   // Alignment state machine
   // ****************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !en_i) begin
         state <= out_of_alignment_state;
         good <= 3'h0;
         exp_code <= 2'h0;
      end else if (ma_en_i) begin
         exp_code <= ptl_next_code(code_i); // Resync to each code
         case (state)
            aligned_state: begin
               if (!seq_ok) begin
                  state <= out_of_alignment_state;
                  good <= 3'h0;
               end
            end
            out_of_alignment_state: begin
               if (!seq_ok) begin
                  good <= 3'h0;
               end else if (good == 3'(ALIGN_N - 1)) begin
                  state <= aligned_state;
                  good <= 3'h0;
               end else begin
                  good <= good + 3'h1;
               end
            end
            default: state <= out_of_alignment_state;
         endcase
      end
   end

   // ****************************************************
   // Loss timer: runs while out of alignment
   // ****************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !en_i || state == aligned_state) begin
         timer <= '0;
         lom_o <= 1'b0;
      end else if (timer == TW'(LOM_N)) begin
         lom_o <= 1'b1;
      end else begin
         timer <= timer + TW'(1);
      end
   end

   assign aligned_o = (state == aligned_state);
   // Phase marker from the recovered sequence
   assign mf_start_o = ma_en_i && aligned_o && code_i == MF_START_CODE;

   // ****************************************************
   // Checks
   // ****************************************************
   oom_on_error_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      en_i && aligned_o && ma_en_i && !seq_ok ##1 en_i |-> !aligned_o)
      else $error("sequence error did not drop alignment");

   lom_clear_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      aligned_o |=> !lom_o)
      else $error("loss of multiframe held while aligned");

   lom_timer_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      $rose(lom_o) |-> timer == TW'(LOM_N) && !$past(aligned_o))
      else $error("loss of multiframe raised at wrong time");

   no_early_align_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      $rose(aligned_o) |-> $past(good) == 3'(ALIGN_N - 1))
      else $error("aligned before enough clean frames");

   realign_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(aligned_o));

endmodule

// ==== rtl/ptl_sink.sv ====
// Top of the tug3 label and multiframe sink with its register slave
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
module ptl_sink
   import ptl_pkg::*;
#(
   parameter int LOM_N = LOM_CYCLES,
   parameter int ACCEPT_N = ACCEPT_FRAMES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Stream from the path termination
   input wire ptl_strm_s strm_i,
   input wire logic upstream_trail_fail_in_i,
   // Stream towards the tributary sinks
   output ptl_strm_s strm_o,
   output logic multiframe_start_out_o,
   output logic tu3_fail_out_o,
   output logic tug2_fail_out_o,
   // Fault causes
   output logic label_mismatch_fault_cause_o,
   output logic multiframe_loss_fault_cause_o,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Interrupt
   output logic irq_o
);

   // ****************************************************
   // Declarations
   // ****************************************************
   logic function_activate;           // Control bit, software owned
   ptl_trib_s trib;                   // Tributary selector register
   logic [1:0] int_stat;              // Sticky event bits
   logic [1:0] int_mask;              // Event enables
   logic [2:0] accepted;              // Accepted structure label
   logic payload_label_mismatch_defect;
   logic multiframe_loss_defect;
   logic aligned;                     // Aligner in its locked state
   logic mf_start;                    // Phase marker, unregistered
   logic next_plm_cause;              // Gated mismatch cause
   logic next_lom_cause;              // Gated loss cause
   logic tu3_fail_action;             // Consequent action, TU-3 side
   logic tug2_fail_action;            // Consequent action, TUG-2 side
   logic req;                         // Any bus request present
   logic acc;                         // Request taken this edge
   logic [1:0] events;                // Rising causes this cycle
   logic [31:0] next_rdata;           // Read mux

   // ****************************************************
   // Label checking
   // ****************************************************
   ptl_label_chk #(
      .ACCEPT_N(ACCEPT_N)
   ) u_label (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .en_i(function_activate),
      .ma_en_i(strm_i.ma_en),
      .label_i(strm_i.data[LABEL_LSB +: 3]),
      .accepted_o(accepted),
      .mismatch_o(payload_label_mismatch_defect)
   );

   // ****************************************************
   // Multiframe alignment
   // ****************************************************
   ptl_mf_align #(
      .LOM_N(LOM_N),
      .ALIGN_N(ALIGN_FRAMES)
   ) u_align (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .en_i(function_activate),
      .ma_en_i(strm_i.ma_en),
      .code_i(strm_i.data[SEQ_LSB +: 2]),
      .aligned_o(aligned),
      .mf_start_o(mf_start),
      .lom_o(multiframe_loss_defect)
   );

   // ****************************************************
   // Consequent actions and fault causes
   // ****************************************************
   // Inactive forces both fail actions; defects are held idle then
   always_comb begin
      tu3_fail_action = !function_activate
         || payload_label_mismatch_defect;
      tug2_fail_action = !function_activate
         || payload_label_mismatch_defect
         || multiframe_loss_defect;
      next_plm_cause = function_activate
         && payload_label_mismatch_defect
         && !upstream_trail_fail_in_i;
      next_lom_cause = function_activate
         && multiframe_loss_defect
         && !upstream_trail_fail_in_i
         && !payload_label_mismatch_defect;
   end

   // Registered outputs towards the tributaries and management
   // Every tributary sink sees the same stream; none is arbitrated
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         strm_o <= '0;
         multiframe_start_out_o <= 1'b0;
         tu3_fail_out_o <= 1'b1;
         tug2_fail_out_o <= 1'b1;
         label_mismatch_fault_cause_o <= 1'b0;
         multiframe_loss_fault_cause_o <= 1'b0;
      end else begin
         strm_o <= strm_i;
         multiframe_start_out_o <= mf_start;
         tu3_fail_out_o <= tu3_fail_action;
         tug2_fail_out_o <= tug2_fail_action;
         label_mismatch_fault_cause_o <= next_plm_cause;
         multiframe_loss_fault_cause_o <= next_lom_cause;
      end
   end

   // ****************************************************
   // Avalon-MM handshake
   // ****************************************************
   // Each request waits one cycle, then completes; a fixed latency
   // costs a little bandwidth but keeps the read path registered
   assign req = avs_read_i || avs_write_i;
   assign acc = req && !avs_waitrequest_o;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= !(req && avs_waitrequest_o);
      end
   end

   // Read mux; unmapped addresses read as zero
   always_comb begin
      next_rdata = 32'h0;
      case (avs_address_i)
         CTRL_OFS: next_rdata[0] = function_activate;
         STAT_OFS: begin
            next_rdata[0] = payload_label_mismatch_defect;
            next_rdata[1] = multiframe_loss_defect;
            next_rdata[2] = aligned;
            next_rdata[3] = ptl_trib_ok(trib);
            next_rdata[6:4] = accepted;
            next_rdata[8] = label_mismatch_fault_cause_o;
            next_rdata[9] = multiframe_loss_fault_cause_o;
         end
         INT_STAT_OFS: next_rdata[1:0] = int_stat;
         INT_MASK_OFS: next_rdata[1:0] = int_mask;
         TRIB_OFS: next_rdata[7:0] = trib;
         default: next_rdata = 32'h0;
      endcase
   end

   // Read data is captured in the waiting cycle, stands when released
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         avs_readdata_o <= 32'h0;
      end else if (avs_read_i && avs_waitrequest_o) begin
         avs_readdata_o <= next_rdata;
      end
   end

   // ****************************************************
   // Control registers
   // ****************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         function_activate <= CTRL_RST;
         int_mask <= INT_MASK_RST;
         trib <= TRIB_RST;
      end else if (acc && avs_write_i) begin
         case (avs_address_i)
            CTRL_OFS: function_activate <= avs_writedata_i[0];
            INT_MASK_OFS: int_mask <= avs_writedata_i[1:0];
            TRIB_OFS: trib <= avs_writedata_i[7:0];
            default: trib <= trib;
         endcase
      end
   end

   // ****************************************************
   // Interrupts
   // ****************************************************
   // Events are cause onsets, so suppression when inactive carries over
   assign events = {next_lom_cause && !multiframe_loss_fault_cause_o,
                    next_plm_cause && !label_mismatch_fault_cause_o};

   // A read clears only the bits it returned, so an event that lands
   // after the capture edge waits for the next read; set still wins
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         int_stat <= 2'h0;
      end else if (acc && avs_read_i && avs_address_i == INT_STAT_OFS) begin
         int_stat <= (int_stat & ~avs_readdata_o[1:0]) | events;
      end else begin
         int_stat <= int_stat | events;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(int_stat & int_mask);
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************
   tu3_fail_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      rst_b_i && function_activate |=> tu3_fail_out_o == $past(
         payload_label_mismatch_defect))
      else $error("tu3 fail output does not follow mismatch");

   tug2_fail_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      function_activate && (payload_label_mismatch_defect
         || multiframe_loss_defect) |=> tug2_fail_out_o)
      else $error("tug2 fail output missed a defect");

   inactive_fail_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      !function_activate |=> tu3_fail_out_o && tug2_fail_out_o
         && !label_mismatch_fault_cause_o
         && !multiframe_loss_fault_cause_o)
      else $error("inactive function still reports");

   plm_cause_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      label_mismatch_fault_cause_o |-> $past(!upstream_trail_fail_in_i)
         && $past(payload_label_mismatch_defect))
      else $error("mismatch cause reported under upstream fail");

   lom_cause_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      multiframe_loss_fault_cause_o |-> $past(multiframe_loss_defect)
         && !$past(payload_label_mismatch_defect)
         && !$past(upstream_trail_fail_in_i))
      else $error("loss cause reported while masked");

   mf_start_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      multiframe_start_out_o |-> strm_o.ma_en
         && strm_o.data[SEQ_LSB +: 2] == MF_START_CODE)
      else $error("multiframe start not on the start code");

   bus_wait_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      req && avs_waitrequest_o ##1 req
         |-> !avs_waitrequest_o)
      else $error("bus request not answered after one wait cycle");

   // ****************************************************
   // Interrupt and register checks
   // ****************************************************
   plm_event_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      $rose(label_mismatch_fault_cause_o) |-> int_stat[INT_PLM_BIT])
      else $error("mismatch cause onset not latched");

   lom_event_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      $rose(multiframe_loss_fault_cause_o) |-> int_stat[INT_LOM_BIT])
      else $error("loss cause onset not latched");

   irq_level_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      irq_o == $past(|(int_stat & int_mask)))
      else $error("interrupt does not follow unmasked status");

   ctrl_write_a: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      acc && avs_write_i && avs_address_i == CTRL_OFS |=>
         function_activate == $past(avs_writedata_i[0]))
      else $error("activation write did not land");

   plm_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(label_mismatch_fault_cause_o));
   lom_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(multiframe_loss_fault_cause_o));
   mfs_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      multiframe_start_out_o);
   irq_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(irq_o));

endmodule

// ==== dv/ptl_src_model.sv ====
// Upstream path termination model feeding framed bytes to the sink
`timescale 1ns/1ns
module ptl_src_model
   import ptl_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Scenario controls
   input wire logic [2:0] label_i,
   input wire logic bad_i,
   // Stream out
   output ptl_strm_s strm_o
);
   // ************************************************
   // Four-beat frames, status byte on beat one
   // ************************************************
   logic [1:0] ph;   // Beat within frame
   logic [1:0] code; // Sequence code of current frame
   logic [7:0] cnt;  // Filler that changes every beat
   // Advance frame beat; a frozen code is the sequence fault we inject
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ph <= 2'h0;
         code <= 2'h0;
         cnt <= 8'h00;
      end else begin
         ph <= ph + 2'h1;
         cnt <= cnt + 8'h01;
         if (ph == 2'h1 && !bad_i) begin
            code <= code + 2'h1;
         end
      end
   end
   // Filler bytes are a running count that can equal the status byte, so stale data mostly shows up
   always_comb begin
      strm_o.fs = (ph == 2'h0);
      strm_o.ma_en = (ph == 2'h1) && rst_b_i;
      strm_o.data = strm_o.ma_en ? {2'h0, label_i, code, 1'h0} : cnt;
   end
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the tug3 label and multiframe sink
`timescale 1ns/1ns
module testbench
   import ptl_pkg::*;
;
   // ************************************************
   // Stimulus, wiring and counters
   // ************************************************
   localparam int LOM_SIM = 200; // Short loss wait keeps the run brief
   logic clk_i = 1'h0;
   logic rst_b_i = 1'h0;
   logic [2:0] label = EXP_LABEL; // Label the source sends
   logic bad = 1'h0;              // Freeze the sequence code
   logic up_fail = 1'h0;
   logic [4:0] avs_address_i = 5'h00;
   logic avs_read_i = 1'h0;
   logic avs_write_i = 1'h0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic irq_o;
   ptl_strm_s strm_i;
   ptl_strm_s strm_o;
   ptl_strm_s prev;               // Input beat one cycle back
   logic multiframe_start_out_o;
   logic tu3_fail_out_o;
   logic tug2_fail_out_o;
   logic label_mismatch_fault_cause_o;
   logic multiframe_loss_fault_cause_o;
   logic [3:0] flags;             // Fail outs then causes
   logic [31:0] rd;               // Last read word
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   int mfs_cnt = 0;
   assign flags = {tu3_fail_out_o, tug2_fail_out_o,
      label_mismatch_fault_cause_o, multiframe_loss_fault_cause_o};
   always #4 clk_i = ~clk_i;
   ptl_src_model src (.clk_i(clk_i), .rst_b_i(rst_b_i), .label_i(label),
      .bad_i(bad), .strm_o(strm_i));
   ptl_sink #(.LOM_N(LOM_SIM)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .strm_i(strm_i), .upstream_trail_fail_in_i(up_fail),
      .strm_o(strm_o), .multiframe_start_out_o(multiframe_start_out_o),
      .tu3_fail_out_o(tu3_fail_out_o), .tug2_fail_out_o(tug2_fail_out_o),
      .label_mismatch_fault_cause_o(label_mismatch_fault_cause_o),
      .multiframe_loss_fault_cause_o(multiframe_loss_fault_cause_o),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));
   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // One bus cycle; an edge first, so back-to-back calls never clash
   task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d);
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_read_i <= !w;
      avs_write_i <= w;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'h0);
      rd = avs_readdata_o;
      avs_read_i <= 1'h0;
      avs_write_i <= 1'h0;
   endtask
   task automatic frames(input int n);
      repeat (4 * n) @(posedge clk_i);
   endtask
   // Pass-through watched from cycle 26 on, start pulse on every edge
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 25) chk({22'h0, strm_o}, {22'h0, prev}, "pass beat");
      prev = strm_i;
      if (multiframe_start_out_o === 1'h1) begin
         mfs_cnt++;
         chk({31'h0, strm_o.ma_en && strm_o.data[2:1] == MF_START_CODE},
            32'h1, "start beat");
      end
      if (cyc == 6000) begin
         error_cnt++;
         $display("mismatch at %0t: timeout", $time);
         tally_and_finish();
      end
   end
   // ************************************************
   // Scenarios
   // ************************************************
   task automatic t_regs();
      logic [4:0] ad [4] = '{CTRL_OFS, INT_MASK_OFS, TRIB_OFS, 5'h14};
      logic [31:0] ex [4] = '{32'h1, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 4; i++) begin
         bus(1'h0, ad[i], 32'h0);
         chk(rd, ex[i], "reset word");
      end
   endtask
   task automatic t_align();
      frames(8);
      bus(1'h0, STAT_OFS, 32'h0);
      chk(rd, 32'h44, "aligned");
      chk({28'h0, flags}, 32'h0, "clean");
      mfs_cnt = 0;
      frames(8);
      chk(mfs_cnt, 2, "starts");
   endtask
   task automatic t_loss();
      bad <= 1'h1;
      frames(3);
      bus(1'h0, STAT_OFS, 32'h0);
      chk(rd, 32'h40, "out of alignment");
      mfs_cnt = 0;
      frames(20);
      chk(mfs_cnt, 0, "no start");
      bus(1'h0, STAT_OFS, 32'h0);
      chk(rd, 32'h40, "loss too early");
      frames(30);
      bus(1'h0, STAT_OFS, 32'h0);
      chk(rd, 32'h242, "loss");
      chk({28'h0, flags}, 32'h5, "loss outs");
      chk({31'h0, irq_o}, 32'h0, "masked");
      bus(1'h1, INT_MASK_OFS, 32'h2);
      frames(1);
      chk({31'h0, irq_o}, 32'h1, "irq up");
      bus(1'h0, INT_STAT_OFS, 32'h0);
      chk(rd, 32'h2, "event");
      frames(1);
      chk({31'h0, irq_o}, 32'h0, "irq cleared");
      up_fail <= 1'h1;
      frames(1);
      chk({28'h0, flags}, 32'h4, "loss hidden");
      up_fail <= 1'h0;
      bad <= 1'h0;
      frames(6);
      bus(1'h0, STAT_OFS, 32'h0);
      chk(rd, 32'h44, "recovered");
      chk({28'h0, flags}, 32'h0, "recovered outs");
   endtask
   task automatic t_label();
      label <= 3'h5;
      frames(7);
      bus(1'h0, STAT_OFS, 32'h0);
      chk(rd, 32'h155, "mismatch");
      chk({28'h0, flags}, 32'he, "mismatch outs");
      up_fail <= 1'h1;
      frames(1);
      chk({28'h0, flags}, 32'hc, "mismatch hidden");
      up_fail <= 1'h0;
      label <= EXP_LABEL;
      frames(7);
      bus(1'h0, INT_STAT_OFS, 32'h0);
      chk(rd, 32'h3, "mismatch event");
      chk({28'h0, flags}, 32'h0, "label back");
   endtask
   task automatic t_inactive();
      bus(1'h1, CTRL_OFS, 32'h0);
      frames(2);
      chk({28'h0, flags}, 32'hc, "inactive outs");
      bus(1'h0, STAT_OFS, 32'h0);
      chk(rd & 32'h303, 32'h0, "inactive status");
      bus(1'h1, CTRL_OFS, 32'h1);
      frames(7);
      bus(1'h0, STAT_OFS, 32'h0);
      chk(rd, 32'h44, "active again");
   endtask
   task automatic t_trib();
      logic [7:0] tv [3] = '{8'h36, 8'h1a, 8'h81};
      logic [31:0] ex [3] = '{32'h4c, 32'h44, 32'h4c};
      for (int i = 0; i < 3; i++) begin
         bus(1'h1, TRIB_OFS, {24'h0, tv[i]});
         bus(1'h0, TRIB_OFS, 32'h0);
         chk(rd, {24'h0, tv[i]}, "trib word");
         bus(1'h0, STAT_OFS, 32'h0);
         chk(rd, ex[i], "trib legal");
      end
   endtask
   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      repeat (20) @(posedge clk_i);
      chk({28'h0, flags}, 32'hc, "reset outs");
      rst_b_i <= 1'h1;
      t_regs();
      t_align();
      t_loss();
      t_label();
      t_inactive();
      t_trib();
      tally_and_finish();
   end
endmodule
